/* hdl/dcs_pkg.sv */
package dcs_pkg;
  localparam int CW_W = 16;
  // control word bit positions
  localparam int CB_REF0 = 0;
  localparam int CB_REF1 = 1;
  localparam int CB_DCBRK_N = 2;
  localparam int CB_COAST_N = 3;
  localparam int CB_QSTOP_N = 4;
  localparam int CB_HOLD_N = 5;
  localparam int CB_START = 6;
  localparam int CB_RESET = 7;
  localparam int CB_JOG = 8;
  localparam int CB_RAMP2 = 9;
  localparam int CB_VALID = 10;
  localparam int CB_RLY1 = 11;
  localparam int CB_RLY2 = 12;
  localparam int CB_SET0 = 13;
  localparam int CB_SET1 = 14;
  localparam int CB_REV = 15;
  // status word bit positions
  localparam int SB_CTRL_RDY = 0;
  localparam int SB_DRV_RDY = 1;
  localparam int SB_ENABLE = 2;
  localparam int SB_TRIP = 3;
  localparam int SB_ERR = 4;
  localparam int SB_TRIP_LOCK = 6;
  localparam int SB_WARN = 7;
  localparam int SB_SPD_EQ = 8;
  localparam int SB_BUS_CTRL = 9;
  localparam int SB_FREQ_OK = 10;
  localparam int SB_IN_OP = 11;
  localparam int SB_BRAKE = 12;
  localparam int SB_VOLT = 13;
  localparam int SB_TORQUE = 14;
  localparam int SB_TIMER = 15;
  // setting codes
  localparam logic [7:0] RLY_FN_CW11 = 8'h24;
  localparam logic [7:0] RLY_FN_CW12 = 8'h25;
  localparam logic [7:0] SETUP_MULTI = 8'h09;
  localparam logic [3:0] PROFILE_NATIVE = 4'h0;
  localparam logic [15:0] CW_RESET_VAL = 16'h0000;
  localparam logic [1:0] SEL_RESET_VAL = 2'h0;
  localparam logic [1:0] BRK_NONE = 2'h0;

  // stop mode chosen from the latched command word and the coast, DC brake and reset-coast inputs
  typedef enum logic [4:0] {
    ST_COAST = 5'h01,
    ST_DCBRAKE = 5'h02,
    ST_QSTOP = 5'h04,
    ST_RSTOP = 5'h08,
    ST_RUN = 5'h10
  } dcs_stop_t;
endpackage

/* hdl/dcs_edge_if.sv */
`timescale 1ns/1ns
interface dcs_edge_if;
  logic level;
  logic rise;
  modport det (input level, output rise);
  modport user (output level, input rise);
endinterface

/* hdl/dcs_edge.sv */
`timescale 1ns/1ns
module dcs_edge
  import dcs_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // level in, pulse out
  dcs_edge_if.det e
);
  typedef struct packed {
    logic prev;
    logic rise;
  } dcs_edge_st_t;
  dcs_edge_st_t s_reg, s_next;

  always_comb begin
    s_next = s_reg;
    s_next.prev = e.level;
    s_next.rise = e.level & ~s_reg.prev;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign e.rise = s_reg.rise;
endmodule

/* hdl/dcs_word.sv */
`timescale 1ns/1ns
// Behaviour
// - decode only with native drive profile selected
// - bits 1:0 pick one of four presets
// - bit 2 low: DC brake and stop
// - bit 3 low: output stage off, coast
// - bit 4 low: quick stop ramp
// - bit 5 low: freeze output frequency
// - frozen: stop only by coast/brake/inputs
// - bit 6 low: ramp stop; high permits start
// - trip reset only on bit 7 rise
// - bit 8 high selects jog speed
// - bit 9 selects ramp set two
// - bit 10 low: whole word ignored
// - relays follow bits 11/12 if selected
// - bits 14:13 pick set-up in multi mode
// - bit 15 reverses if direction allows
// - status 0: low tripped, high control ready
// - status 2: low released, high startable
// - status 3,4,6,7 faults; 5 unused
// - status 8: speed equals reference
// - status 9: fieldbus control possible
// - status 10 limits ok; 11 operating
// - status 12..15 brake, volt, torque, timer
module dcs_word
  import dcs_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // command word from the fieldbus master
  input wire logic [15:0] drive_command_word,
  input wire logic cmd_wr,
  // settings
  input wire logic [3:0] profile_sel,
  input wire logic [7:0] relay1_fn,
  input wire logic [7:0] relay2_fn,
  input wire logic [7:0] active_setup_sel,
  input wire logic reverse_allowed,
  // digital input functions
  input wire logic di_coast,
  input wire logic di_dcbrake,
  input wire logic di_reset_coast,
  input wire logic di_speed_up,
  input wire logic di_speed_down,
  // drive state inputs
  input wire logic tripped,
  input wire logic trip_locked,
  input wire logic error_no_trip,
  input wire logic warning,
  input wire logic power_ready,
  input wire logic speed_at_ref,
  input wire logic local_stop,
  input wire logic local_ref,
  input wire logic freq_in_limits,
  input wire logic freq_nonzero,
  input wire logic brake_fault,
  input wire logic dc_volt_bad,
  input wire logic torque_over,
  input wire logic thermal_over,
  // drive commands
  output logic [1:0] preset_sel,
  output logic [4:0] stop_mode,
  output logic freq_hold,
  output logic freq_step_up,
  output logic freq_step_down,
  output logic trip_reset,
  output logic jog_sel,
  output logic ramp2_sel,
  output logic relay1_on,
  output logic relay2_on,
  output logic [1:0] setup_sel,
  output logic reverse,
  output logic start_req,
  // status back to the master
  output logic [15:0] drive_state_word
);
  typedef struct packed {
    logic [15:0] cw;
    logic [1:0] preset;
    dcs_stop_t mode;
    logic hold;
    logic up;
    logic down;
    logic trst;
    logic jog;
    logic ramp2;
    logic r1;
    logic r2;
    logic [1:0] setup;
    logic rev;
    logic start;
    logic [15:0] sw;
  } dcs_word_st_t;
  dcs_word_st_t s_reg, s_next;

  dcs_edge_if rst_edge();

  logic accept;
  logic [15:0] cw;
  logic di_stop;

  function automatic logic bitv(input logic [15:0] w, input int pos);
    bitv = w[pos];
  endfunction

  // a word is acted on only under the native profile and with valid set
  assign accept = cmd_wr && (profile_sel == PROFILE_NATIVE)
    && drive_command_word[CB_VALID];
  assign cw = accept ? drive_command_word : s_reg.cw;
  assign di_stop = di_coast | di_dcbrake | di_reset_coast;
  assign rst_edge.level = bitv(s_reg.cw, CB_RESET);

  dcs_edge u_edge (
    .mclk(mclk),
    .rst(rst),
    .e(rst_edge.det)
  );

  always_comb begin
    s_next = s_reg;
    s_next.cw = cw;
    s_next.preset = {cw[CB_REF1], cw[CB_REF0]};
    s_next.hold = ~bitv(cw, CB_HOLD_N);
    // stop priority: coast beats brake beats quick stop beats ramp stop
    if (!bitv(cw, CB_COAST_N) || di_coast || di_reset_coast) begin
      s_next.mode = ST_COAST;
    end else if (!bitv(cw, CB_DCBRK_N) || di_dcbrake) begin
      s_next.mode = ST_DCBRAKE;
    end else if (s_next.hold) begin
      // frozen: quick and ramp stop bits do not stop the motor
      s_next.mode = ST_RUN;
    end else if (!bitv(cw, CB_QSTOP_N)) begin
      s_next.mode = ST_QSTOP;
    end else if (!bitv(cw, CB_START)) begin
      s_next.mode = ST_RSTOP;
    end else begin
      s_next.mode = ST_RUN;
    end
    // frozen frequency only moves by speed up/down inputs
    s_next.up = s_next.hold & di_speed_up & ~di_stop;
    s_next.down = s_next.hold & di_speed_down & ~di_stop;
    s_next.start = (s_next.mode == ST_RUN) & bitv(cw, CB_START);
    s_next.trst = rst_edge.rise & tripped;
    s_next.jog = bitv(cw, CB_JOG);
    s_next.ramp2 = bitv(cw, CB_RAMP2);
    s_next.r1 = (relay1_fn == RLY_FN_CW11) & bitv(cw, CB_RLY1);
    s_next.r2 = (relay2_fn == RLY_FN_CW12) & bitv(cw, CB_RLY2);
    if (active_setup_sel == SETUP_MULTI) begin
      s_next.setup = {cw[CB_SET1], cw[CB_SET0]};
    end
    s_next.rev = bitv(cw, CB_REV) & reverse_allowed;
    // status word
    s_next.sw = '0;
    s_next.sw[SB_CTRL_RDY] = ~tripped & ~trip_locked;
    s_next.sw[SB_DRV_RDY] = power_ready & ~tripped & ~trip_locked;
    s_next.sw[SB_ENABLE] = (s_reg.mode != ST_COAST) & ~tripped;
    s_next.sw[SB_TRIP] = tripped;
    s_next.sw[SB_ERR] = error_no_trip;
    s_next.sw[SB_TRIP_LOCK] = trip_locked;
    s_next.sw[SB_WARN] = warning;
    s_next.sw[SB_SPD_EQ] = speed_at_ref;
    s_next.sw[SB_BUS_CTRL] = ~local_stop & ~local_ref;
    s_next.sw[SB_FREQ_OK] = freq_in_limits;
    s_next.sw[SB_IN_OP] = s_reg.start | freq_nonzero;
    s_next.sw[SB_BRAKE] = brake_fault;
    s_next.sw[SB_VOLT] = dc_volt_bad;
    s_next.sw[SB_TORQUE] = torque_over;
    s_next.sw[SB_TIMER] = thermal_over;
  end

  // reset state is coasting, so the motor never starts before a word arrives
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.cw <= CW_RESET_VAL;
      s_reg.mode <= ST_COAST;
      s_reg.preset <= SEL_RESET_VAL;
      s_reg.setup <= SEL_RESET_VAL;
    end else begin
      s_reg <= s_next;
    end
  end

  assign preset_sel = s_reg.preset;
  assign stop_mode = s_reg.mode;
  assign freq_hold = s_reg.hold;
  assign freq_step_up = s_reg.up;
  assign freq_step_down = s_reg.down;
  assign trip_reset = s_reg.trst;
  assign jog_sel = s_reg.jog;
  assign ramp2_sel = s_reg.ramp2;
  assign relay1_on = s_reg.r1;
  assign relay2_on = s_reg.r2;
  assign setup_sel = s_reg.setup;
  assign reverse = s_reg.rev;
  assign start_req = s_reg.start;
  assign drive_state_word = s_reg.sw;
endmodule

/* sim/dcs_chk.sv */
`timescale 1ns/1ns
module dcs_chk
  import dcs_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [15:0] drive_command_word,
  input wire logic cmd_wr,
  input wire logic [3:0] profile_sel,
  input wire logic tripped,
  input wire logic trip_locked,
  input wire logic di_coast,
  input wire logic di_dcbrake,
  input wire logic di_reset_coast,
  input wire logic [1:0] preset_sel,
  input wire logic [4:0] stop_mode,
  input wire logic jog_sel,
  input wire logic trip_reset,
  input wire logic [15:0] drive_state_word
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic [15:0] w;
  logic tk;
  logic last7_reg;
  logic di_any;
  assign w = drive_command_word;
  assign di_any = di_coast | di_dcbrake | di_reset_coast;
  assign tk = cmd_wr && profile_sel == 4'h0 && w[CB_VALID];
  // only a rise between taken words counts as a reset request
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      last7_reg <= 1'b0;
    end else if (tk) begin
      last7_reg <= w[CB_RESET];
    end
  end
  chk_preset_pick: assert property (tk |=> preset_sel == $past(w[1:0]))
    else $error("preset select wrong");
  chk_word_ignored: assert property (!tk |=> $stable(preset_sel) && $stable(jog_sel))
    else $error("ignored word changed outputs");
  chk_jog_pick: assert property (tk |=> jog_sel == $past(w[CB_JOG]))
    else $error("jog select wrong");
  chk_coast_first: assert property (tk && !w[3] |=> stop_mode == ST_COAST)
    else $error("coast not applied");
  chk_dc_brake: assert property (tk && w[3:2] == 2'h2 && !di_coast && !di_reset_coast
    |=> stop_mode == ST_DCBRAKE) else $error("dc brake not applied");
  chk_quick_stop: assert property (tk && w[5:2] == 4'hB && !di_any
    |=> stop_mode == ST_QSTOP) else $error("quick stop not applied");
  // the pulse leaves the design two edges after the word is taken
  chk_trip_edge: assert property (tk && w[CB_RESET] && !last7_reg ##2 tripped
    |=> trip_reset) else $error("trip reset missing");
  chk_ready_trip: assert property (!$past(rst) |->
    drive_state_word[0] == !$past(tripped || trip_locked)
    && drive_state_word[3] == $past(tripped)) else $error("ready or trip flag wrong");
endmodule
bind dcs_word dcs_chk chk_u (.*);

/* sim/dcs_master.sv */
`timescale 1ns/1ns
// fieldbus master offering one command word per call
module dcs_master (
  input wire logic mclk,
  output logic cmd_wr,
  output logic [15:0] word
);
  initial begin
    cmd_wr = 1'b0;
    word = 16'h0000;
  end
  task automatic send(input logic [15:0] v);
    @(posedge mclk);
    cmd_wr <= 1'b1;
    word <= v;
    @(posedge mclk);
    cmd_wr <= 1'b0;
    word <= ~v;  // word is not held once the offer is over
  endtask
endmodule

/* sim/drive_control_status_word_bench.sv */
`timescale 1ns/1ns
`define CHK(a, b) chk_val(16'(a), 16'(b))
module drive_control_status_word_bench;
  import dcs_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic cmd_wr;
  logic [15:0] word, sw, ew = 16'h0000;
  logic [3:0] prof = 4'h0;
  logic [7:0] r1fn = 8'h00, r2fn = 8'h00, asel = 8'h00;
  logic [13:0] st = 14'h0000;
  logic [1:0] ps, ss, eset = 2'h0;
  logic [4:0] sm;
  logic su, sd, sr;
  logic [4:0] di = 5'h00;
  logic rok = 1'b0, fh, tr, jg, r2, y1, y2, rv, e1 = 1'b0, e2 = 1'b0, erv = 1'b0;
  int error_cnt = 0, samples_checked = 0, cyc = 0, pulses = 0;
  always #5 mclk = ~mclk;
  dcs_master m_u (.mclk(mclk), .cmd_wr(cmd_wr), .word(word));
  dcs_word dut_u (.mclk(mclk), .rst(rst), .drive_command_word(word), .cmd_wr(cmd_wr),
    .profile_sel(prof), .relay1_fn(r1fn), .relay2_fn(r2fn), .active_setup_sel(asel),
    .reverse_allowed(rok), .di_coast(di[0]), .di_dcbrake(di[1]), .di_reset_coast(di[2]),
    .di_speed_up(di[3]), .di_speed_down(di[4]), .tripped(st[0]), .trip_locked(st[1]),
    .error_no_trip(st[2]), .warning(st[3]), .power_ready(st[4]), .speed_at_ref(st[5]),
    .local_stop(st[6]), .local_ref(st[7]), .freq_in_limits(st[8]), .freq_nonzero(st[9]),
    .brake_fault(st[10]), .dc_volt_bad(st[11]), .torque_over(st[12]), .thermal_over(st[13]),
    .preset_sel(ps), .stop_mode(sm), .freq_hold(fh), .freq_step_up(su), .freq_step_down(sd),
    .trip_reset(tr), .jog_sel(jg), .ramp2_sel(r2), .relay1_on(y1), .relay2_on(y2),
    .setup_sel(ss), .reverse(rv), .start_req(sr), .drive_state_word(sw));
  // d: reset-coast, dc brake and coast inputs in bits 2..0
  function automatic logic [4:0] exp_stop(input logic [15:0] w, input logic [4:0] d);
    if (!w[CB_COAST_N] || d[0] || d[2]) return ST_COAST;
    if (!w[CB_DCBRK_N] || d[1]) return ST_DCBRAKE;
    if (!w[CB_HOLD_N]) return ST_RUN;
    if (!w[CB_QSTOP_N]) return ST_QSTOP;
    if (!w[CB_START]) return ST_RSTOP;
    return ST_RUN;
  endfunction
  function automatic logic [15:0] exp_sw(input logic [13:0] s, input logic [15:0] w,
    input logic [4:0] d);
    logic run;
    logic on;
    run = exp_stop(w, d) == ST_RUN && w[CB_START];
    on = exp_stop(w, d) != ST_COAST;
    return {s[13:10], run | s[9], s[8], !(s[6] | s[7]), s[5], s[3], s[1], 1'b0, s[2], s[0],
      on & !s[0], s[4] & !(s[0] | s[1]), !(s[0] | s[1])};
  endfunction
  task automatic chk_val(input logic [15:0] a, input logic [15:0] b);
    samples_checked++;
    if (a !== b) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, a, b);
    end
  endtask
  task automatic step(input logic [15:0] w, input logic [3:0] p, input logic [13:0] s);
    logic tk, rise, ro;
    logic [7:0] f1, f2, a;
    logic [4:0] d;
    logic [15:0] xs;
    tk = p == 4'h0 && w[CB_VALID];
    rise = tk && w[CB_RESET] && !ew[CB_RESET] && s[0];
    f1 = $urandom_range(0, 1) ? RLY_FN_CW11 : RLY_FN_CW12;
    f2 = $urandom_range(0, 1) ? RLY_FN_CW12 : RLY_FN_CW11;
    a = $urandom_range(0, 1) ? SETUP_MULTI : 8'h08;
    ro = 1'($urandom_range(0, 1));
    // inputs mostly quiet so that stops coming from the word get exercised
    d = ($urandom_range(0, 3) == 0) ? 5'($urandom) : 5'h00;
    @(posedge mclk);
    prof <= p;
    st <= s;
    r1fn <= f1;
    r2fn <= f2;
    asel <= a;
    rok <= ro;
    di <= d;
    m_u.send(w);
    pulses = 0;
    repeat (3) @(posedge mclk);
    #1;
    // relays, reverse and set-up follow the latched word under the present settings
    if (tk) ew = w;
    e1 = ew[CB_RLY1] && f1 == RLY_FN_CW11;
    e2 = ew[CB_RLY2] && f2 == RLY_FN_CW12;
    erv = ew[CB_REV] && ro;
    if (a == SETUP_MULTI) eset = ew[14:13];
    xs = exp_sw(s, ew, d);
    `CHK(ps, ew[1:0]);
    `CHK(sm, exp_stop(ew, d));
    `CHK(fh, !ew[CB_HOLD_N]);
    `CHK({sd, su}, d[4:3] & {2{!ew[CB_HOLD_N] && d[2:0] == 3'h0}});
    `CHK(sr, exp_stop(ew, d) == ST_RUN && ew[CB_START]);
    `CHK(jg, ew[CB_JOG]);
    `CHK(r2, ew[CB_RAMP2]);
    `CHK({y2, y1}, {e2, e1});
    `CHK(ss, eset);
    `CHK(rv, erv);
    `CHK(sw[0], xs[0]);
    `CHK(sw[2:1], xs[2:1]);
    `CHK(sw[7:3], xs[7:3]);
    `CHK(sw[8], xs[8]);
    `CHK(sw[9], xs[9]);
    `CHK(sw[11:10], xs[11:10]);
    `CHK(sw[15:12], xs[15:12]);
    `CHK(pulses, rise);
  endtask
  task automatic summarize();
    $display("checks=%0d errors=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // counted away from the rising edge so the pulse is read while it stands
  always @(negedge mclk) begin
    cyc++;
    if (tr === 1'b1) pulses++;
    if (cyc == 2000) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    void'($urandom(84));
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    step(16'h047F, 4'h0, 14'h0010);
    step(16'h0400, 4'h0, 14'h0000);
    step(16'h0480, 4'h0, 14'h0001);
    step(16'h0480, 4'h0, 14'h0001);
    step(16'h0403, 4'h3, 14'h0001);
    step(16'hFBFF, 4'h0, 14'h3FFF);
    step(16'h042C, 4'h0, 14'h3FFE);
    step(16'h043C, 4'h0, 14'h0155);
    step(16'hFFFF, 4'h0, 14'h2AAA);
    repeat (60) step(16'($urandom), 4'($urandom_range(0, 3) == 0), 14'($urandom));
    summarize();
  end
endmodule
